// >>> rtl/sw_ind_pkg.sv
/*
 * Shared constants for the switch decoder and lamp controller: register
 * offsets, field positions, reset values, modes, states and blink timing.
 * Assumes a 50 MHz reference clock and a 32-bit plain register port.
 */
package sw_ind_pkg;

    // Clock and blink timing
    localparam int unsigned CLK_HZ            = 50_000_000;
    localparam int unsigned BLINK_HALF_MS     = 250;
    localparam int unsigned BLINK_HALF_CYCLES =
        (CLK_HZ / 1000) * BLINK_HALF_MS;
    // Synchroniser fill time before the switch is captured
    localparam logic [1:0]  SETTLE_CYCLES     = 2'h2;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] CMD_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // Control register fields
    localparam int CTRL_W            = 10;
    localparam int CTRL_READY_BIT    = 0;
    localparam int CTRL_XFER_BIT     = 1;
    localparam int CTRL_MOVE_BIT     = 2;
    localparam int CTRL_ERR_BIT      = 3;
    localparam int CTRL_NET_USE_BIT  = 4;
    localparam int CTRL_NET_CFG_BIT  = 5;
    localparam int CTRL_NET_CARD_BIT = 6;
    localparam int CTRL_SOCK1_BIT    = 7;
    localparam int CTRL_SOCK2_BIT    = 8;
    localparam int CTRL_SWAP_BIT     = 9;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

    // Command register fields, each a one-cycle action
    localparam int CMD_BEGUN_BIT   = 0;
    localparam int CMD_DONE_BIT    = 1;
    localparam int CMD_CLR_REQ_BIT = 2;
    localparam int CMD_RESTART_BIT = 3;

    // Status register fields
    localparam int ST_MODE_LSB    = 0;
    localparam int ST_TYPE_BIT    = 2;
    localparam int ST_SLOT_BIT    = 3;
    localparam int ST_LEVEL_BIT   = 4;
    localparam int ST_BAD_BIT     = 5;
    localparam int ST_FSM_LSB     = 6;
    localparam int ST_REQ_BIT     = 8;
    localparam int ST_LAMP_LSB    = 9;
    localparam int ST_CAPT_BIT    = 14;

    // Switch pins, pin 1 at index 0
    localparam int PIN_LEVEL = 0;
    localparam int PIN_START = 1;
    localparam int PIN_SLOT  = 2;
    localparam int PIN_TYPE  = 3;
    localparam int PIN_MODE0 = 4;
    localparam int PIN_MODE1 = 5;
    localparam logic [5:0] SW_DEFAULT = 6'h00;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_XFER   = 2'h1,
        MODE_FORMAT = 2'h2,
        MODE_BAD    = 2'h3
    } mode_t;

    typedef enum logic [1:0] {
        FS_OFF     = 2'h0,
        FS_STANDBY = 2'h1,
        FS_BUSY    = 2'h3,
        FS_DONE    = 2'h2
    } fmt_state_t;

endpackage

// >>> rtl/blink_gen.sv
/*
 * Blink phase generator: a free counter that flips a phase flag every
 * HALF_CYCLES clocks. Assumes one clock and an asynchronous low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module blink_gen #(
    parameter int unsigned HALF_CYCLES = 4
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Phase out
    output logic      blink_q
);
    localparam int CW = $clog2(HALF_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    logic [CW-1:0] cnt_q;
    wire           wrap = (cnt_q == LAST);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            blink_q <= 1'b0;
        end else if (wrap) begin
            cnt_q   <= '0;
            blink_q <= ~blink_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

`default_nettype wire

// >>> rtl/switch_mode_indicator_ctrl.sv
/*
 * Switch decoder, card format sequencer and status lamp driver for a
 * memory-card expansion unit. Holds a plain register port for the unit's
 * firmware. Assumes the six switch pins are asynchronous and the unit
 * restart is rst_n or the restart command.
 */
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module switch_mode_indicator_ctrl #(
    parameter int unsigned BLINK_HALF = sw_ind_pkg::BLINK_HALF_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Configuration switch, pin 1 at bit 0
    input  wire logic [5:0]  sw_pin,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Decoded settings
    output logic      [1:0]  startup_mode,
    output logic             format_flash,
    output logic             format_slot_two,
    output logic             level_zero,
    // Lamps
    output logic             run_lamp,
    output logic             error_lamp,
    output logic             socket_one_activity_lamp,
    output logic             socket_two_activity_lamp,
    output logic             format_lamp
);
    // Switch synchroniser
    logic [5:0] sw_s1_q;
    logic [5:0] sw_s2_q;
    logic       start_prev_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_s1_q <= sw_ind_pkg::SW_DEFAULT;
            sw_s2_q <= sw_ind_pkg::SW_DEFAULT;
        end else begin
            sw_s1_q <= sw_pin;
            sw_s2_q <= sw_s1_q;
        end
    end

    // Register decode
    wire wr_ctrl = reg_wr && (reg_addr == sw_ind_pkg::CTRL_OFS);
    wire wr_cmd  = reg_wr && (reg_addr == sw_ind_pkg::CMD_OFS);
    wire cmd_begun   = wr_cmd && reg_wdata[sw_ind_pkg::CMD_BEGUN_BIT];
    wire cmd_done    = wr_cmd && reg_wdata[sw_ind_pkg::CMD_DONE_BIT];
    wire cmd_clr_req = wr_cmd && reg_wdata[sw_ind_pkg::CMD_CLR_REQ_BIT];
    wire cmd_restart = wr_cmd && reg_wdata[sw_ind_pkg::CMD_RESTART_BIT];

    // Capture at restart, once the synchroniser holds real pin levels
    logic [1:0]             settle_q;
    logic                   captured_q;
    sw_ind_pkg::mode_t      mode_q;
    logic                   type_q;
    logic                   slot_q;
    logic                   level_q;
    wire                    capture_now = !captured_q &&
                            (settle_q == sw_ind_pkg::SETTLE_CYCLES);
    wire [1:0]              mode_pins = {sw_s2_q[sw_ind_pkg::PIN_MODE1],
                                         sw_s2_q[sw_ind_pkg::PIN_MODE0]};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_q   <= 2'h0;
            captured_q <= 1'b0;
            mode_q     <= sw_ind_pkg::MODE_NORMAL;
            type_q     <= 1'b0;
            slot_q     <= 1'b0;
            level_q    <= 1'b0;
        end else if (cmd_restart) begin
            settle_q   <= 2'h0;
            captured_q <= 1'b0;
        end else if (capture_now) begin
            captured_q <= 1'b1;
            mode_q     <= sw_ind_pkg::mode_t'(mode_pins);
            type_q     <= sw_s2_q[sw_ind_pkg::PIN_TYPE];
            slot_q     <= sw_s2_q[sw_ind_pkg::PIN_SLOT];
            level_q    <= sw_s2_q[sw_ind_pkg::PIN_LEVEL];
        end else if (!captured_q) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    // Start pin edge of either direction, valid only in format standby
    sw_ind_pkg::fmt_state_t fsm_q;
    logic                   req_q;
    logic                   capture_q_edge;
    wire start_pin    = sw_s2_q[sw_ind_pkg::PIN_START];
    wire start_toggle = captured_q && (start_pin != start_prev_q);
    wire start_take   = start_toggle &&
                        (fsm_q == sw_ind_pkg::FS_STANDBY);
    wire mode_bad     = captured_q && (mode_q == sw_ind_pkg::MODE_BAD);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= start_pin;
        end
    end

    // Pending request: a new toggle beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= 1'b0;
        end else if (start_take) begin
            req_q <= 1'b1;
        end else if (cmd_clr_req || cmd_begun || !captured_q) begin
            req_q <= 1'b0;
        end
    end

    // Format sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fsm_q <= sw_ind_pkg::FS_OFF;
        end else if (!captured_q) begin
            fsm_q <= sw_ind_pkg::FS_OFF;
        end else begin
            unique case (fsm_q)
                sw_ind_pkg::FS_OFF: begin
                    if (capture_q_edge && mode_q == sw_ind_pkg::MODE_FORMAT)
                        fsm_q <= sw_ind_pkg::FS_STANDBY;
                end
                sw_ind_pkg::FS_STANDBY: begin
                    if (cmd_begun && req_q)
                        fsm_q <= sw_ind_pkg::FS_BUSY;
                end
                sw_ind_pkg::FS_BUSY: begin
                    if (cmd_done)
                        fsm_q <= sw_ind_pkg::FS_DONE;
                end
                sw_ind_pkg::FS_DONE: begin
                    fsm_q <= sw_ind_pkg::FS_DONE;
                end
            endcase
        end
    end

    // One cycle after capture, the latched mode is settled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_q_edge <= 1'b0;
        end else begin
            capture_q_edge <= capture_now;
        end
    end

    // Firmware control word
    logic [sw_ind_pkg::CTRL_W-1:0] ctrl_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= sw_ind_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata[sw_ind_pkg::CTRL_W-1:0];
        end
    end

    // Blink phase shared by all flashing lamps
    logic blink;
    blink_gen #(
        .HALF_CYCLES (BLINK_HALF)
    ) u_blink (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .blink_q (blink)
    );

    // Lamp terms
    wire c_ready = ctrl_q[sw_ind_pkg::CTRL_READY_BIT];
    wire c_xfer  = ctrl_q[sw_ind_pkg::CTRL_XFER_BIT];
    wire c_move  = ctrl_q[sw_ind_pkg::CTRL_MOVE_BIT];
    wire c_err   = ctrl_q[sw_ind_pkg::CTRL_ERR_BIT];
    wire c_net   = ctrl_q[sw_ind_pkg::CTRL_NET_USE_BIT];
    wire c_ncfg  = ctrl_q[sw_ind_pkg::CTRL_NET_CFG_BIT];
    wire c_ncard = ctrl_q[sw_ind_pkg::CTRL_NET_CARD_BIT];
    wire c_s1    = ctrl_q[sw_ind_pkg::CTRL_SOCK1_BIT];
    wire c_s2    = ctrl_q[sw_ind_pkg::CTRL_SOCK2_BIT];
    wire c_swap  = ctrl_q[sw_ind_pkg::CTRL_SWAP_BIT];
    wire busy    = (fsm_q == sw_ind_pkg::FS_BUSY);

    // Swap darkening wins, so a card change never shows as a run flash
    wire run_d = c_swap ? 1'b0 :
                 c_move ? blink : (c_ready || c_xfer);
    wire err_d = c_err || (c_net && (c_ncfg || c_ncard)) ||
                 mode_bad;
    wire s1_d  = (busy && !slot_q) ? blink : c_s1;
    wire s2_d  = (busy && slot_q) ? blink : c_s2;
    wire fmt_d = (fsm_q == sw_ind_pkg::FS_STANDBY) ? blink :
                 busy;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_lamp                 <= 1'b0;
            error_lamp               <= 1'b0;
            socket_one_activity_lamp <= 1'b0;
            socket_two_activity_lamp <= 1'b0;
            format_lamp              <= 1'b0;
        end else begin
            run_lamp                 <= run_d;
            error_lamp               <= err_d;
            socket_one_activity_lamp <= s1_d;
            socket_two_activity_lamp <= s2_d;
            format_lamp              <= fmt_d;
        end
    end

    // Decoded settings out, level 0 when pin 1 is on
    assign startup_mode    = mode_q;
    assign format_flash    = type_q;
    assign format_slot_two = slot_q;
    assign level_zero      = level_q;

    // Read path, data valid only in the cycle after the strobe
    wire [4:0]  lamps = {format_lamp, socket_two_activity_lamp,
                         socket_one_activity_lamp, error_lamp, run_lamp};
    wire [31:0] status_word = {17'h00000, captured_q, lamps, req_q,
                               fsm_q, mode_bad, level_q, slot_q,
                               type_q, mode_q};
    wire [31:0] rd_mux =
        (reg_addr == sw_ind_pkg::CTRL_OFS)   ? {22'h000000, ctrl_q} :
        (reg_addr == sw_ind_pkg::STATUS_OFS) ? status_word : 32'h00000000;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    // Checks
    property p_mode_decode;
        @(posedge ref_clk) disable iff (!rst_n)
        capture_now && !cmd_restart |=> mode_q == $past(mode_pins);
    endproperty
    a_mode_decode: assert property (p_mode_decode)
        else $error("startup mode not taken from pins 6 and 5");

    property p_type_decode;
        @(posedge ref_clk) disable iff (!rst_n)
        capture_now && !cmd_restart |=> type_q == $past(sw_s2_q[3]);
    endproperty
    a_type_decode: assert property (p_type_decode)
        else $error("format type not taken from pin 4");

    property p_slot_decode;
        @(posedge ref_clk) disable iff (!rst_n)
        capture_now && !cmd_restart |=> slot_q == $past(sw_s2_q[2]);
    endproperty
    a_slot_decode: assert property (p_slot_decode)
        else $error("format slot not taken from pin 3");

    property p_level_decode;
        @(posedge ref_clk) disable iff (!rst_n)
        capture_now && !cmd_restart |=> level_zero == $past(sw_s2_q[0]);
    endproperty
    a_level_decode: assert property (p_level_decode)
        else $error("operating level not taken from pin 1");

    property p_start_req;
        @(posedge ref_clk) disable iff (!rst_n)
        fsm_q == sw_ind_pkg::FS_STANDBY && start_pin != start_prev_q
        |=> req_q;
    endproperty
    a_start_req: assert property (p_start_req)
        else $error("start pin change did not raise a request");

    property p_start_ignored;
        @(posedge ref_clk) disable iff (!rst_n)
        mode_q != sw_ind_pkg::MODE_FORMAT |-> !req_q && !busy;
    endproperty
    a_start_ignored: assert property (p_start_ignored)
        else $error("start request outside format mode");

    property p_hold_settings;
        @(posedge ref_clk) disable iff (!rst_n)
        captured_q ##1 captured_q |-> $stable(mode_q) && $stable(level_q);
    endproperty
    a_hold_settings: assert property (p_hold_settings)
        else $error("settings changed without a restart");

    property p_fmt_blink;
        @(posedge ref_clk) disable iff (!rst_n)
        fsm_q == sw_ind_pkg::FS_STANDBY |=> format_lamp == $past(blink);
    endproperty
    a_fmt_blink: assert property (p_fmt_blink)
        else $error("format lamp not blinking in standby");

    property p_fmt_busy;
        @(posedge ref_clk) disable iff (!rst_n)
        busy ##1 busy |-> format_lamp;
    endproperty
    a_fmt_busy: assert property (p_fmt_busy)
        else $error("format lamp not steady while formatting");

    property p_fmt_done;
        @(posedge ref_clk) disable iff (!rst_n)
        busy && cmd_done |=> ##1 !format_lamp;
    endproperty
    a_fmt_done: assert property (p_fmt_done)
        else $error("format lamp still on after completion");

    property p_err_lamp;
        @(posedge ref_clk) disable iff (!rst_n)
        c_err || mode_bad |=> error_lamp;
    endproperty
    a_err_lamp: assert property (p_err_lamp)
        else $error("error lamp dark on a fault");

    c_begin: cover property (@(posedge ref_clk) disable iff (!rst_n)
        fsm_q == sw_ind_pkg::FS_STANDBY ##1 busy);
    c_finish: cover property (@(posedge ref_clk) disable iff (!rst_n)
        busy ##1 fsm_q == sw_ind_pkg::FS_DONE);
    c_bad_mode: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(mode_bad));
endmodule

`default_nettype wire

// >>> sim/switch_operator.sv
/*
 * Operator model at the configuration switch: turns a wanted setting into
 * switch pin levels, keeping the operator's duties at the switch.
 * Assumes running is low only while the unit is held in restart.
 */
`timescale 1ns/1ps
`default_nettype none

module switch_operator (
    // Clock and run state
    input  wire logic       ref_clk,
    input  wire logic       running,
    // Wanted setting, pin 1 at bit 0
    input  wire logic [5:0] want_sw,
    // Switch pins
    output logic      [5:0] sw_pin
);
    logic [5:0] sw_q = 6'h00;
    wire logic       normal_w = (want_sw[5:4] == 2'h0);
    // Pins 2 to 4 stay off whenever normal startup is chosen
    wire logic [2:0] mid_w    = normal_w ? 3'h0 : want_sw[3:1];

    always @(posedge ref_clk) begin
        sw_q[5:1] <= {want_sw[5:4], mid_w};
        // The level pin moves only while the unit is stopped; the wanted
        // level is assumed apart from any link unit sharing the bus
        if (!running) begin
            sw_q[0] <= want_sw[0];
        end
    end

    assign sw_pin = sw_q;
endmodule

`default_nettype wire

// >>> sim/testbench.sv
/*
 * Self-checking bench for the switch decoder and lamp controller.
 * Assumes a short blink half period and the operator model on the pins.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int unsigned HALF = 4;
    logic        ref_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [5:0]  want_sw   = 6'h00;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    wire logic [5:0]  sw_pin;
    wire logic [31:0] reg_rdata;
    wire logic [1:0]  startup_mode;
    wire logic        format_flash, format_slot_two, level_zero;
    wire logic        run_lamp, error_lamp, format_lamp;
    wire logic        socket_one_activity_lamp, socket_two_activity_lamp;
    wire logic [4:0]  lamps = {format_lamp, socket_two_activity_lamp,
                               socket_one_activity_lamp, error_lamp,
                               run_lamp};
    int err_total   = 0;
    int checks_done = 0;

    always #10 ref_clk = ~ref_clk;

    switch_operator u_switch_operator (
        .ref_clk (ref_clk),
        .running (rst_n),
        .want_sw (want_sw),
        .sw_pin  (sw_pin)
    );

    switch_mode_indicator_ctrl #(
        .BLINK_HALF (HALF)
    ) u_switch_mode_indicator_ctrl (
        .ref_clk                  (ref_clk),
        .rst_n                    (rst_n),
        .sw_pin                   (sw_pin),
        .reg_addr                 (reg_addr),
        .reg_wdata                (reg_wdata),
        .reg_wr                   (reg_wr),
        .reg_rd                   (reg_rd),
        .reg_rdata                (reg_rdata),
        .startup_mode             (startup_mode),
        .format_flash             (format_flash),
        .format_slot_two          (format_slot_two),
        .level_zero               (level_zero),
        .run_lamp                 (run_lamp),
        .error_lamp               (error_lamp),
        .socket_one_activity_lamp (socket_one_activity_lamp),
        .socket_two_activity_lamp (socket_two_activity_lamp),
        .format_lamp              (format_lamp)
    );

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] mask, exp);
        logic [31:0] d;
        rd(a, d);
        chk(nm, d & mask, exp);
    endtask

    // Full restart; the operator may move every pin while it is held
    task automatic restart(input logic [5:0] sw);
        @(posedge ref_clk);
        rst_n   <= 1'b0;
        want_sw <= sw;
        repeat (6) @(posedge ref_clk);
        rst_n   <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    // Lamp history over more than one blink period: {seen on, seen off}
    task automatic lamp(input string nm, input int idx,
                        input logic [1:0] exp);
        logic lo;
        logic hi;
        lo = 1'b0;
        hi = 1'b0;
        repeat (2) @(posedge ref_clk);
        repeat (12) begin
            @(posedge ref_clk);
            #1;
            if (lamps[idx] === 1'b0) lo = 1'b1;
            if (lamps[idx] === 1'b1) hi = 1'b1;
        end
        chk(nm, {hi, lo}, exp);
    endtask

    task automatic wait_pending;
        logic [31:0] d;
        for (int i = 0; i < 10; i++) begin
            rd(sw_ind_pkg::STATUS_OFS, d);
            if (d[sw_ind_pkg::ST_REQ_BIT] === 1'b1) break;
        end
        chk("start pending", d[sw_ind_pkg::ST_REQ_BIT], 1'b1);
        if (d[sw_ind_pkg::ST_REQ_BIT] !== 1'b1) wrap_up();
    endtask

    task automatic t_defaults;
        chk("default settings", {startup_mode, format_flash,
            format_slot_two, level_zero}, 5'h00);
        chk("default error lamp", error_lamp, 1'b0);
    endtask

    task automatic t_decode;
        logic [5:0]  sw;
        logic [31:0] d;
        for (int m = 0; m < 4; m++) begin
            sw = {m[1:0], m[0], m[1], 1'b0, m[0]};
            restart(sw);
            chk("mode", startup_mode, sw[5:4]);
            chk("format type", format_flash, sw[3]);
            chk("format slot", format_slot_two, sw[2]);
            chk("level", level_zero, sw[0]);
            chk("bad mode lamp", error_lamp, m == 3);
            rd(sw_ind_pkg::STATUS_OFS, d);
            chk("status settings", d[5:0],
                {m == 3, sw[0], sw[2], sw[3], sw[5:4]});
        end
    endtask

    task automatic t_capture;
        logic [31:0] d;
        restart(6'h10);
        @(posedge ref_clk);
        want_sw <= 6'h22;
        repeat (8) @(posedge ref_clk);
        #1;
        chk("mode held", startup_mode, 2'h1);
        rd(sw_ind_pkg::STATUS_OFS, d);
        chk("start ignored", d[8:6], 3'h0);
        chk("format lamp idle", format_lamp, 1'b0);
        wr(sw_ind_pkg::CMD_OFS, 32'h8);
        repeat (8) @(posedge ref_clk);
        #1;
        chk("mode recaptured", startup_mode, 2'h2);
    endtask

    task automatic t_format;
        restart(6'h24);
        rd_chk("standby", sw_ind_pkg::STATUS_OFS, 32'hc0, 32'h40);
        lamp("format standby", 4, 2'b11);
        @(posedge ref_clk);
        want_sw <= 6'h26;
        wait_pending();
        wr(sw_ind_pkg::CMD_OFS, 32'h4);
        rd_chk("pending cleared", sw_ind_pkg::STATUS_OFS,
               32'h100, 32'h0);
        @(posedge ref_clk);
        want_sw <= 6'h24;
        wait_pending();
        wr(sw_ind_pkg::CMD_OFS, 32'h1);
        lamp("format busy", 4, 2'b10);
        lamp("slot two busy", 3, 2'b11);
        lamp("slot one idle", 2, 2'b01);
        wr(sw_ind_pkg::CMD_OFS, 32'h2);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("format lamp off", format_lamp, 1'b0);
        lamp("format done", 4, 2'b01);
        rd_chk("done", sw_ind_pkg::STATUS_OFS, 32'hc0, 32'h80);
    endtask

    task automatic t_lamps;
        restart(6'h00);
        wr(sw_ind_pkg::CTRL_OFS, 32'h1);
        lamp("run ready", 0, 2'b10);
        wr(sw_ind_pkg::CTRL_OFS, 32'h2);
        lamp("run transfer", 0, 2'b10);
        wr(sw_ind_pkg::CTRL_OFS, 32'h4);
        lamp("run moving", 0, 2'b11);
        wr(sw_ind_pkg::CTRL_OFS, 32'h205);
        lamp("run card swap", 0, 2'b01);
        wr(sw_ind_pkg::CTRL_OFS, 32'h8);
        lamp("error internal", 1, 2'b10);
        wr(sw_ind_pkg::CTRL_OFS, 32'h30);
        lamp("error net setup", 1, 2'b10);
        wr(sw_ind_pkg::CTRL_OFS, 32'h50);
        lamp("error net card", 1, 2'b10);
        wr(sw_ind_pkg::CTRL_OFS, 32'h80);
        lamp("socket one", 2, 2'b10);
        lamp("socket two idle", 3, 2'b01);
        wr(sw_ind_pkg::CTRL_OFS, 32'h100);
        lamp("socket two", 3, 2'b10);
        lamp("socket one idle", 2, 2'b01);
        wr(sw_ind_pkg::CTRL_OFS, 32'hffff_ffff);
        rd_chk("control readback", sw_ind_pkg::CTRL_OFS,
               32'hffff_ffff, 32'h3ff);
        rd_chk("unmapped read", 8'hfc, 32'hffff_ffff, 32'h0);
        wr(sw_ind_pkg::CTRL_OFS, 32'h0);
    endtask

    initial begin
        restart(6'h00);
        t_defaults();
        t_decode();
        t_capture();
        t_format();
        t_lamps();
        wrap_up();
    end
endmodule

`default_nettype wire
